/* File: core/slpl_core.v */
// serial port with stop-level retention, loop and single-wire modes
// assumes apb master on clk_sys and pins synchronous to clk_sys
//
// Contract
// R01: stop levels halt all serial activity
// R02: middle and deepest stop clear registers
// R03: shallow stop retains every register
// R04: edge detector runs shallow, not middle
// R05: shallow rx edge wakes if enabled
// R06: resume from retained state after shallow
// R07: software avoids stop mid-character
// R08: receiver source picks loop or single-wire
// R09: loop mode feeds tx to rx
// R10: single-wire joins rx, tx, transmit pin
// R11: direction zero makes transmit pin input
// R12: direction one drives transmit pin
// R13: single-wire receiver hears own transmissions
// R14: loop clear means normal full duplex
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "slpl_defines.vh"

module slpl_core (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// chip stop level
	input  wire [1:0]  stop_level,
	// pins
	input  wire        txd_i,
	output wire        txd_o,
	output wire        txd_oe,
	input  wire        rxd_i,
	output wire        rxd_pin_owned,
	// events
	output wire        wake_o,
	output wire        irq
);

	// ****************************************
	// stop level decode
	// ****************************************
	wire       run_lvl;
	wire       shallow;
	wire       lost;
	assign run_lvl = (stop_level == `SLPL_RUN);
	assign shallow = (stop_level == `SLPL_SHALLOW);
	assign lost    = (stop_level == `SLPL_MIDDLE) | (stop_level == `SLPL_DEEPEST); // R02

	// ****************************************
	// registers
	// ****************************************
	reg  [3:0]  ctrl_r;
	reg  [15:0] baud_r;
	reg  [2:0]  stat_r;
	reg  [2:0]  mask_r;
	reg  [7:0]  rx_data_r;
	reg         tx_busy_r;
	reg  [15:0] tx_cnt_r;
	reg  [3:0]  tx_bit_r;
	reg  [9:0]  tx_sh_r;
	reg         rx_busy_r;
	reg  [15:0] rx_cnt_r;
	reg  [3:0]  rx_bit_r;
	reg  [7:0]  rx_sh_r;
	reg         rx_prev_r;
	reg  [2:0]  stat_nxt;

	wire        loop_select;
	wire        receiver_source_select;
	wire        single_wire_tx_direction;
	wire        rx_edge_wake_enable;
	assign loop_select              = ctrl_r[`SLPL_CTRL_LOOP];
	assign receiver_source_select   = ctrl_r[`SLPL_CTRL_RECEIVER_SOURCE_SELECT];
	assign single_wire_tx_direction = ctrl_r[`SLPL_CTRL_TDIR];
	assign rx_edge_wake_enable      = ctrl_r[`SLPL_CTRL_WAKE];

	// ****************************************
	// pin and receiver source steering
	// ****************************************
	wire tx_line;
	wire single_wire;
	wire rx_in;
	assign tx_line     = tx_busy_r ? tx_sh_r[0] : 1'b1;
	assign single_wire = loop_select & receiver_source_select; // R08
	// loop: rx hears tx; single-wire: rx hears the shared pin line
	assign rx_in = ~loop_select ? rxd_i :           // R14
	               ~receiver_source_select ? tx_line : // R09
	               single_wire_tx_direction ? tx_line : // R10 R13
	               txd_i;                            // R11
	assign txd_o  = tx_line;                         // R12 R14
	assign txd_oe = ~(single_wire & ~single_wire_tx_direction); // R11 R12
	assign rxd_pin_owned = ~loop_select;             // R09 R10

	// ****************************************
	// receive active-edge detector and wake
	// ****************************************
	wire edge_on;
	wire rx_edge;
	assign edge_on = run_lvl | shallow;               // R04
	assign rx_edge = edge_on & rx_prev_r & ~rx_in;
	assign wake_o  = shallow & rx_edge & rx_edge_wake_enable; // R05

	// previous receive level, forced high in the middle and deepest levels
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_prev_r <= 1'b1;
		end else if (lost) begin
			rx_prev_r <= 1'b1;                        // R02
		end else if (edge_on) begin
			rx_prev_r <= rx_in;                       // R04
		end
	end

	// ****************************************
	// apb decode
	// ****************************************
	wire       acc;
	wire       wr;
	wire       hit;
	assign hit = (paddr == `SLPL_OFS_CTRL) | (paddr == `SLPL_OFS_BAUD) |
	             (paddr == `SLPL_OFS_DATA) | (paddr == `SLPL_OFS_STAT) |
	             (paddr == `SLPL_OFS_MASK);
	assign acc     = psel & penable;
	assign wr      = acc & pwrite & hit & run_lvl;    // R01
	assign pready  = 1'b1;                            // zero wait states
	assign pslverr = acc & ~hit;

	// read data captured in the setup phase
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable) begin
			case (paddr)
			`SLPL_OFS_CTRL: prdata <= {28'h0, ctrl_r};
			`SLPL_OFS_BAUD: prdata <= {16'h0, baud_r};
			`SLPL_OFS_DATA: prdata <= {24'h0, rx_data_r};
			`SLPL_OFS_STAT: prdata <= {27'h0, rx_busy_r, tx_busy_r, stat_r};
			`SLPL_OFS_MASK: prdata <= {29'h0, mask_r};
			default:        prdata <= 32'h0000_0000;
			endcase
		end
	end

	// control, baud and mask registers
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `SLPL_CTRL_RST;
			baud_r <= `SLPL_BAUD_RST;
			mask_r <= 3'h0;
		end else if (lost) begin
			ctrl_r <= `SLPL_CTRL_RST;                 // R02
			baud_r <= `SLPL_BAUD_RST;
			mask_r <= 3'h0;
		end else if (wr) begin                        // R03: held in shallow, written only while running
			if (paddr == `SLPL_OFS_CTRL) ctrl_r <= pwdata[3:0];
			if (paddr == `SLPL_OFS_BAUD) baud_r <= pwdata[15:0];
			if (paddr == `SLPL_OFS_MASK) mask_r <= pwdata[2:0];
		end
	end

	// ****************************************
	// transmitter
	// ****************************************
	wire tx_start;
	wire tx_tick;
	assign tx_start = wr & (paddr == `SLPL_OFS_DATA) & ~tx_busy_r;
	assign tx_tick  = run_lvl & tx_busy_r & (tx_cnt_r == 16'h0000);

	// shift start, eight data bits and stop, lsb first
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy_r <= 1'b0;
			tx_cnt_r  <= 16'h0000;
			tx_bit_r  <= 4'h0;
			tx_sh_r   <= 10'h3ff;
		end else if (lost) begin
			tx_busy_r <= 1'b0;                        // R02
			tx_cnt_r  <= 16'h0000;
			tx_bit_r  <= 4'h0;
			tx_sh_r   <= 10'h3ff;
		end else if (tx_start) begin
			tx_busy_r <= 1'b1;
			tx_cnt_r  <= baud_r - 16'h0001;
			tx_bit_r  <= 4'h0;
			tx_sh_r   <= {1'b1, pwdata[7:0], 1'b0};
		end else if (tx_tick) begin
			tx_cnt_r <= baud_r - 16'h0001;
			tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
			tx_bit_r <= tx_bit_r + 4'h1;
			if (tx_bit_r == `SLPL_LAST_BIT) begin
				tx_busy_r <= 1'b0;
			end
		end else if (run_lvl & tx_busy_r) begin       // R01 R06
			tx_cnt_r <= tx_cnt_r - 16'h0001;
		end
	end

	// ****************************************
	// receiver
	// ****************************************
	wire rx_start;
	wire rx_tick;
	wire rx_done;
	assign rx_start = run_lvl & ~rx_busy_r & rx_edge;
	assign rx_tick  = run_lvl & rx_busy_r & (rx_cnt_r == 16'h0000);
	assign rx_done  = rx_tick & (rx_bit_r == `SLPL_LAST_BIT) & rx_in;

	// sample mid-bit; a start bit gone high is treated as noise
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_busy_r <= 1'b0;
			rx_cnt_r  <= 16'h0000;
			rx_bit_r  <= 4'h0;
			rx_sh_r   <= 8'h00;
			rx_data_r <= 8'h00;
		end else if (lost) begin
			rx_busy_r <= 1'b0;                        // R02
			rx_cnt_r  <= 16'h0000;
			rx_bit_r  <= 4'h0;
			rx_sh_r   <= 8'h00;
			rx_data_r <= 8'h00;
		end else if (rx_start) begin
			rx_busy_r <= 1'b1;
			rx_cnt_r  <= {1'b0, baud_r[15:1]};
			rx_bit_r  <= 4'h0;
		end else if (rx_tick) begin
			rx_cnt_r <= baud_r - 16'h0001;
			rx_bit_r <= rx_bit_r + 4'h1;
			if (rx_bit_r == 4'h0) begin
				rx_busy_r <= ~rx_in;
			end else if (rx_bit_r == `SLPL_LAST_BIT) begin
				rx_busy_r <= 1'b0;
				if (rx_in) begin
					rx_data_r <= rx_sh_r;
				end
			end else begin
				rx_sh_r <= {rx_in, rx_sh_r[7:1]};
			end
		end else if (run_lvl & rx_busy_r) begin       // R01 R06
			rx_cnt_r <= rx_cnt_r - 16'h0001;
		end
	end

	// ****************************************
	// sticky status and interrupt
	// ****************************************
	wire [2:0] ev;
	wire [2:0] clr;
	assign ev[`SLPL_ST_TXDONE] = tx_tick & (tx_bit_r == `SLPL_LAST_BIT);
	assign ev[`SLPL_ST_RXFULL] = rx_done;
	assign ev[`SLPL_ST_RXEDGE] = rx_edge;              // R04
	assign clr = (wr & (paddr == `SLPL_OFS_STAT)) ? pwdata[2:0] : 3'h0;

	// set wins over a write-one clear in the same cycle
	always @* begin
		stat_nxt = (stat_r & ~clr) | ev;
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= 3'h0;
		end else if (lost) begin
			stat_r <= 3'h0;                           // R02
		end else begin
			stat_r <= stat_nxt;                       // R03
		end
	end

	assign irq = |(stat_r & mask_r);

endmodule

/* File: core/slpl_defines.vh */
// constants for the serial port low-power and loopback block
// assumes a 40 mhz module clock and a 32-bit apb register bus
`ifndef SLPL_DEFINES_VH
`define SLPL_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define SLPL_OFS_CTRL   8'h00
`define SLPL_OFS_BAUD   8'h04
`define SLPL_OFS_DATA   8'h08
`define SLPL_OFS_STAT   8'h0c
`define SLPL_OFS_MASK   8'h10

// ****************************************
// control field positions and reset value
// ****************************************
`define SLPL_CTRL_LOOP  0
`define SLPL_CTRL_RECEIVER_SOURCE_SELECT  1
`define SLPL_CTRL_TDIR  2
`define SLPL_CTRL_WAKE  3
`define SLPL_CTRL_RST   4'h0

// ****************************************
// status field positions (bits 0 to 2 sticky, write one to clear; busy bits live)
// ****************************************
`define SLPL_ST_TXDONE  0
`define SLPL_ST_RXFULL  1
`define SLPL_ST_RXEDGE  2
`define SLPL_ST_TXBUSY  3
`define SLPL_ST_RXBUSY  4

// ****************************************
// stop level encodings, baud reset value and last frame bit index
// ****************************************
`define SLPL_RUN        2'h0
`define SLPL_SHALLOW    2'h1
`define SLPL_MIDDLE     2'h2
`define SLPL_DEEPEST    2'h3
`define SLPL_BAUD_RST   16'h015b
`define SLPL_LAST_BIT   4'h9

`endif

/* File: tb/slpl_far_dev.sv */
// far serial device on the rx pin and the transmit pin
// assumes 8n1 frames of BIT_CYC clk_sys cycles a bit
`timescale 1ns/1ps
module slpl_far_dev #(
	parameter BIT_CYC = 4
) (
	// clock
	input  wire clk_sys,
	// pins
	input  wire line_i,
	output reg  rxd_o = 1'b1,
	output reg  tp_en = 1'b0,
	output reg  tp_val = 1'b1
);
	// send a frame lsb first, pins idle high
	task send(input [7:0] b, input tp);
		integer   i;
		reg [9:0] f;
		begin
			f = {1'b1, b, 1'b0};
			tp_en <= tp;
			for (i = 0; i < 10; i = i + 1) begin
				rxd_o <= tp | f[i];
				tp_val <= f[i];
				repeat (BIT_CYC) @(posedge clk_sys);
			end
			tp_en <= 1'b0; // pull-up holds the pin after release
		end
	endtask
	// take a frame from the transmit pin at mid bit
	task recv(output [7:0] b);
		integer i;
		begin
			@(negedge line_i);
			repeat (BIT_CYC / 2) @(posedge clk_sys);
			for (i = 0; i < 8; i = i + 1) begin
				repeat (BIT_CYC) @(posedge clk_sys);
				b[i] = line_i;
			end
		end
	endtask
endmodule

/* File: tb/slpl_monitor.sv */
// checker on the serial port block ports
// assumes one clock clk_sys and rst_n active low
`timescale 1ns/1ps
module slpl_monitor (
	// clock, reset
	input wire        clk_sys,
	input wire        rst_n,
	// apb
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire        pready,
	input wire        pslverr,
	input wire [31:0] prdata,
	// stop and pins
	input wire [1:0]  stop_level,
	input wire        txd_o,
	input wire        txd_oe,
	input wire        rxd_pin_owned,
	input wire        wake_o,
	input wire        irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// apb answers
	ready_high_a: assert property (pready) else $error("pready low");
	bad_addr_a: assert property (psel && penable |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
		else $error("pslverr wrong");
	err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read not zero");
	// stop levels and pins
	stop_hold_a: assert property (stop_level == 2'h1 && $past(stop_level) == 2'h1 |->
		$stable(txd_o) && $stable(txd_oe)) else $error("shallow stop moved");
	resume_hold_a: assert property ($past(stop_level) == 2'h1 && !stop_level |-> $stable(txd_o))
		else $error("resume jumped");
	deep_clear_a: assert property (stop_level[1] && $past(stop_level[1]) |->
		rxd_pin_owned && txd_oe && txd_o && !irq) else $error("deep stop kept state");
	wake_stop_a: assert property (wake_o |-> stop_level == 2'h1) else $error("wake outside shallow");
	oe_pin_a: assert property (!txd_oe |-> !rxd_pin_owned) else $error("rx pin kept");
endmodule
bind slpl_core slpl_monitor slpl_monitor_inst (.*);

/* File: tb/tb_serial_port_lowpower_loopback.sv */
// self-checking bench for the serial port block
// assumes slpl_core, the far device model and the bound checker
`timescale 1ns/1ps
`include "slpl_defines.vh"
module tb_serial_port_lowpower_loopback;
	reg         clk_sys, rst_n, psel, penable, pwrite, se;
	reg  [7:0]  paddr, b, g;
	reg  [31:0] pwdata, rv;
	reg  [1:0]  stop_level;
	wire        pready, pslverr, txd_o, txd_oe, txd_i, rxd_i, rxd_pin_owned, wake_o, irq, tp_en, tp_val;
	wire [31:0] prdata;
	integer     seed, errors, check_count, m, n, cyc = 0, wake_cnt = 0;
	// transmit pin: design, far device, else pull-up
	assign txd_i = txd_oe ? txd_o : (tp_en ? tp_val : 1'b1);
	slpl_core slpl_core_inst (.*);
	slpl_far_dev #(.BIT_CYC(4)) slpl_far_dev_inst (.clk_sys(clk_sys), .line_i(txd_i), .rxd_o(rxd_i),
		.tp_en(tp_en), .tp_val(tp_val));
	// clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// cycle ceiling and wake catcher
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (wake_o === 1'b1) wake_cnt <= wake_cnt + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			stop_test;
		end
	end
	function [31:0] cv(input l, s, d, w);
		cv = {28'h0, w, d, s, l};
	endfunction
	task chk(input string nm, input [31:0] e, v);
		begin
			check_count = check_count + 1;
			if (v !== e) begin
				errors = errors + 1;
				$display("MISMATCH %s exp %h got %h", nm, e, v);
			end
		end
	endtask
	// apb setup, then access until pready
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge clk_sys);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk_sys);
			penable <= 1'b1;
			@(posedge clk_sys);
			while (pready !== 1'b1) @(posedge clk_sys);
			rv = prdata;
			se = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rc(input [7:0] a, input [31:0] e, input string nm);
		begin
			apb(1'b0, a, 32'h0);
			chk(nm, e, rv);
		end
	endtask
	// poll a status bit, bounded
	task ws(input integer k);
		begin
			n = 0;
			rv = 32'h0;
			while (rv[k] !== 1'b1 && n < 100) begin
				apb(1'b0, `SLPL_OFS_STAT, 32'h0);
				n = n + 1;
			end
			chk("stat_bit", 1, rv[k]);
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d errors %0d", check_count, errors);
			if (errors == 0 && check_count > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	// main sequence
	initial begin
		seed = 32'hf8a84e2f;
		errors = 0;
		check_count = 0;
		{psel, penable, pwrite, paddr, pwdata, stop_level} = 0;
		rst_n = 1'b0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		rc(`SLPL_OFS_CTRL, 32'h0, "ctrl_reset");
		rc(`SLPL_OFS_BAUD, 32'h15b, "baud_reset");
		rc(8'h14, 32'h0, "unmapped");
		chk("unmapped_err", 1, se);
		apb(1'b1, `SLPL_OFS_BAUD, 32'h4);
		for (m = 0; m < 4; m = m + 1) begin
			b = $random(seed);
			apb(1'b1, `SLPL_OFS_STAT, 32'h7);
			apb(1'b1, `SLPL_OFS_CTRL, cv(m > 0, m > 1, m == 2, 1'b0));
			@(posedge clk_sys);
			chk("pin_owned", m == 0, rxd_pin_owned);
			chk("tx_enable", m != 3, txd_oe);
			if (m == 3) slpl_far_dev_inst.send(b, 1'b1);
			else begin
				fork
					slpl_far_dev_inst.recv(g);
					apb(1'b1, `SLPL_OFS_DATA, {24'h0, b});
				join
				chk("pin_byte", b, g);
				ws(0);
			end
			if (m == 0) begin
				b = $random(seed);
				slpl_far_dev_inst.send(b, 1'b0);
			end
			ws(1);
			rc(`SLPL_OFS_DATA, b, "rx_byte");
		end
		// interrupt raise, mask, clear
		apb(1'b1, `SLPL_OFS_MASK, 32'h2);
		@(posedge clk_sys);
		chk("irq_on", 1, irq);
		apb(1'b1, `SLPL_OFS_MASK, 32'h1);
		@(posedge clk_sys);
		chk("irq_masked", 0, irq);
		apb(1'b1, `SLPL_OFS_MASK, 32'h2);
		apb(1'b1, `SLPL_OFS_STAT, 32'h2);
		@(posedge clk_sys);
		chk("irq_clear", 0, irq);
		// each stop level, entered only while idle; pass 0 is shallow with wake disabled
		for (m = 0; m < 4; m = m + 1) begin
			apb(1'b1, `SLPL_OFS_CTRL, cv(0, 0, 0, m != 0));
			n = wake_cnt;
			stop_level <= (m == 0) ? 2'h1 : m[1:0];
			apb(1'b1, `SLPL_OFS_CTRL, 32'h0);
			slpl_far_dev_inst.send(8'h00, 1'b0);
			stop_level <= 2'h0;
			@(posedge clk_sys);
			chk("woke", m == 1, wake_cnt != n);
			rc(`SLPL_OFS_CTRL, m == 1 ? 32'h8 : 32'h0, "ctrl_kept");
			rc(`SLPL_OFS_BAUD, m < 2 ? 32'h4 : 32'h15b, "baud_kept");
		end
		stop_test;
	end
endmodule
